/* File: hdl/hwd_pkg.sv */
package hwd_pkg;

	localparam int WORD_W   = 16;
	localparam int DATA_W   = 12;
	localparam int UNIT_W   = 4;
	localparam int UNITS    = 16;
	localparam int CLK_MHZ  = 10;

	// Top nibble of a word: all ones marks a control word.
	localparam logic [3:0] CTRL_CODE = 4'hf;
	localparam int SLOT_LSB = 12;

	// Field positions of the mode and unit latch.
	localparam int UNIT_LSB   = 0;
	localparam int BIT_WAIT   = 4;
	localparam int BIT_SYSOE  = 5;
	localparam int BIT_SIMUL  = 6;
	localparam int BIT_INSEL  = 7;
	localparam int BIT_INTEN  = 8;
	localparam int LATCH_W    = 9;
	localparam logic [8:0] LATCH_RESET = 9'h000;

	// Handshake-mode answer delay.
	localparam int HS_DELAY_US  = 50;
	localparam int HS_DELAY_CYC = HS_DELAY_US * CLK_MHZ;
	// Cycles the timing wait ignores the busy line so a card's busy can arrive.
	localparam int FOB_SETTLE_CYC = 3;

	typedef struct packed {
		logic       input_interrupt_enable;
		logic       input_select;
		logic       simultaneous_transfer_enable;
		logic       system_output_enable;
		logic       wait_timing_mode;
		logic [3:0] unit_addr;
	} hwd_mode_t;

	typedef struct packed {
		logic [3:0]  slot;
		logic [11:0] data;
	} hwd_word_t;

	typedef enum logic [1:0] {
		HWD_IDLE = 2'b00,
		HWD_HS   = 2'b01,
		HWD_WAIT = 2'b11
	} hwd_state_t;

endpackage

/* File: hdl/hwd_decoder.sv */
// What this block does
// - A word with bits 15..12 all ones is a mode control word.
// - Other words are data (output) or address (input); top bits pick the slot.
// - Control word latches unit address bits 0-3 and mode bits 4-8.
// - Unit address is unsigned, bit 3 most significant; unit 0 is mainframe.
// - Selected unit stays selected until a control word changes the address.
// - Every control word reloads the unit address; zero bits select unit 0.
// - Output mode data word with gate sends bits 0-11 to addressed slot.
// - Handshake mode returns ready about 50 us after a gated word.
// - Timing mode holds busy until the slowest output card is ready.
// - Thirteen return lines echo output data for integrity checking.
// - Input mode returns card data on bits 0-11, request on bit 15.
// - Gated address word with input select arms the card; ungated only reads.
// - With interrupt enable, an armed card becoming ready raises ready.
// - Dedicated input: addressed card data stays on bits 0-11, status on 15.
// - Exactly one unit select line is high at a time.
// - Gate-triggered card actions start on the gate's falling edge.
module hwd_decoder #(
	parameter int HS_CYCLES = hwd_pkg::HS_DELAY_CYC
) (
	input  wire logic                              core_clk,
	input  wire logic                              reset,
	input  wire logic                              clk_en,
	input  wire logic [hwd_pkg::WORD_W-1:0]        host_word,
	input  wire logic                              host_gate_strobe,
	input  wire logic                              flag_override_busy,
	input  wire logic                              card_input_request,
	input  wire logic [hwd_pkg::DATA_W-1:0]        card_return_data,
	input  wire logic                              card_input_ready,
	output logic      [hwd_pkg::WORD_W-1:0]        return_data,
	output logic                                   data_ready,
	output logic      [hwd_pkg::UNITS-1:0]         unit_select,
	output hwd_pkg::hwd_mode_t                     mode,
	output hwd_pkg::hwd_word_t                     card_word,
	output logic                                   output_card_strobe,
	output logic                                   input_card_arm
);

	function automatic logic is_ctrl(input logic [hwd_pkg::WORD_W-1:0] w);
		return w[hwd_pkg::WORD_W-1:hwd_pkg::SLOT_LSB] == hwd_pkg::CTRL_CODE;
	endfunction

	// Pin inputs pass two flip-flops; gate and card ready add a third stage, read for edge detection.
	logic [hwd_pkg::WORD_W-1:0] word_s1_q, word_s2_q;
	logic                       gate_s1_q, gate_s2_q, gate_s3_q;
	logic                       fob_s1_q, fob_s2_q;
	logic                       irq_s1_q, irq_s2_q;
	logic                       rdy_s1_q, rdy_s2_q, rdy_s3_q;
	logic [hwd_pkg::DATA_W-1:0] cdat_s1_q, cdat_s2_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			word_s1_q <= '0;
			word_s2_q <= '0;
			gate_s1_q <= 1'b0;
			gate_s2_q <= 1'b0;
			gate_s3_q <= 1'b0;
			fob_s1_q  <= 1'b0;
			fob_s2_q  <= 1'b0;
			irq_s1_q  <= 1'b0;
			irq_s2_q  <= 1'b0;
			rdy_s1_q  <= 1'b0;
			rdy_s2_q  <= 1'b0;
			rdy_s3_q  <= 1'b0;
			cdat_s1_q <= '0;
			cdat_s2_q <= '0;
		end else if (clk_en) begin
			word_s1_q <= host_word;
			word_s2_q <= word_s1_q;
			gate_s1_q <= host_gate_strobe;
			gate_s2_q <= gate_s1_q;
			gate_s3_q <= gate_s2_q;
			fob_s1_q  <= flag_override_busy;
			fob_s2_q  <= fob_s1_q;
			irq_s1_q  <= card_input_request;
			irq_s2_q  <= irq_s1_q;
			rdy_s1_q  <= card_input_ready;
			rdy_s2_q  <= rdy_s1_q;
			rdy_s3_q  <= rdy_s2_q;
			cdat_s1_q <= card_return_data;
			cdat_s2_q <= cdat_s1_q;
		end
	end

	// The host holds the word stable across the gate, so the word sampled at
	// the falling gate edge is consistent with it.
	logic gate_fall;
	logic ctrl_word;
	logic rdy_rise;
	assign gate_fall = gate_s3_q & ~gate_s2_q;
	assign ctrl_word = is_ctrl(word_s2_q);
	assign rdy_rise  = rdy_s2_q & ~rdy_s3_q;

	hwd_pkg::hwd_mode_t mode_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mode_q <= hwd_pkg::LATCH_RESET;
		end else if (clk_en && gate_fall && ctrl_word) begin
			// Unit address reloads on every control word.
			mode_q <= word_s2_q[hwd_pkg::LATCH_W-1:0];
		end
	end
	assign mode = mode_q;

	// One-hot decode of the stored unit number.
	always_comb begin
		unit_select = '0;
		unit_select[mode_q.unit_addr] = 1'b1;
	end

	// Card slot word and strobes toward the selected unit's cards.
	hwd_pkg::hwd_word_t card_word_q;
	logic               out_stb_q, arm_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			card_word_q <= '0;
			out_stb_q   <= 1'b0;
			arm_q       <= 1'b0;
		end else if (clk_en) begin
			out_stb_q <= 1'b0;
			arm_q     <= 1'b0;
			if (!ctrl_word) begin
				// Address follows the lines so ungated reads still select a card.
				card_word_q.slot <= word_s2_q[hwd_pkg::WORD_W-1:hwd_pkg::SLOT_LSB];
				if (!mode_q.input_select) begin
					card_word_q.data <= word_s2_q[hwd_pkg::DATA_W-1:0];
				end
				if (gate_fall) begin
					out_stb_q <= ~mode_q.input_select;
					arm_q     <= mode_q.input_select;
				end
			end
		end
	end
	assign card_word          = card_word_q;
	assign output_card_strobe = out_stb_q;
	assign input_card_arm     = arm_q;

	// Return lines: echo in output modes, card data and request in input modes.
	logic [hwd_pkg::WORD_W-1:0] ret_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ret_q <= '0;
		end else if (clk_en) begin
			if (mode_q.input_select) begin
				ret_q <= {irq_s2_q, 3'h0, cdat_s2_q};
			end else begin
				ret_q <= {word_s2_q[15], 3'h0, word_s2_q[hwd_pkg::DATA_W-1:0]};
			end
		end
	end
	assign return_data = ret_q;

	// Ready flag sequencing.
	hwd_pkg::hwd_state_t state_q;
	logic [$clog2(HS_CYCLES+1)-1:0] cnt_q;
	logic rdy_q;
	logic data_gate;

	assign data_gate = gate_fall & ~ctrl_word;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= hwd_pkg::HWD_IDLE;
			cnt_q   <= '0;
			rdy_q   <= 1'b1;
		end else if (clk_en) begin
			case (state_q)
				hwd_pkg::HWD_IDLE: begin
					if (data_gate) begin
						rdy_q <= 1'b0;
						cnt_q <= '0;
						if (mode_q.wait_timing_mode || (mode_q.input_select
								&& mode_q.input_interrupt_enable)) begin
							state_q <= hwd_pkg::HWD_WAIT;
						end else begin
							state_q <= hwd_pkg::HWD_HS;
						end
					end else if (mode_q.input_select && mode_q.input_interrupt_enable
							&& rdy_rise) begin
						rdy_q <= 1'b1;
					end
				end
				hwd_pkg::HWD_HS: begin
					// Answer without looking at the cards.
					if (cnt_q == ($bits(cnt_q))'(HS_CYCLES - 1)) begin
						rdy_q   <= 1'b1;
						state_q <= hwd_pkg::HWD_IDLE;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				hwd_pkg::HWD_WAIT: begin
					if (mode_q.input_select && mode_q.input_interrupt_enable) begin
						// An armed card answers by its ready edge, not by busy.
						if (rdy_rise) begin
							rdy_q   <= 1'b1;
							state_q <= hwd_pkg::HWD_IDLE;
						end
					end else if (cnt_q < ($bits(cnt_q))'(hwd_pkg::FOB_SETTLE_CYC)) begin
						cnt_q <= cnt_q + 1'b1;
					end else if (!fob_s2_q) begin
						// The busy line is ORed over all cards, so it clears last.
						rdy_q   <= 1'b1;
						state_q <= hwd_pkg::HWD_IDLE;
					end
				end
				default: begin
					state_q <= hwd_pkg::HWD_IDLE;
					rdy_q   <= 1'b1;
				end
			endcase
		end
	end
	// Card busy right after the gate lags the strobe and its synchroniser, so the
	// timing wait first lets a few cycles pass; a card slower than that is missed.
	assign data_ready = rdy_q;

endmodule

/* File: testbench/hwd_monitor.sv */
module hwd_monitor #(
	parameter int HS_CYCLES = 500
) (
	input wire logic               core_clk,
	input wire logic               reset,
	input wire logic               flag_override_busy,
	input wire logic               card_input_ready,
	input wire logic               data_ready,
	input wire logic [15:0]        unit_select,
	input wire hwd_pkg::hwd_mode_t mode,
	input wire hwd_pkg::hwd_word_t card_word,
	input wire logic               output_card_strobe,
	input wire logic               input_card_arm
);
	timeunit 1ns;
	timeprecision 1ns;
	int lo_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Counts low cycles of the flag, so the handshake answer has a hard bound.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) lo_q <= 0;
		else lo_q <= data_ready ? 0 : lo_q + 1;
	end
	sequence s_busy;
		flag_override_busy [*4];
	endsequence
	chk_reset_clear: assert property ($fell(reset) |-> mode == 9'h000)
		else $error("mode not cleared");
	chk_unit_onehot: assert property ($onehot(unit_select))
		else $error("select not one-hot");
	chk_unit_decode: assert property (unit_select == 16'h0001 << mode.unit_addr)
		else $error("bad unit decode");
	chk_strobe_out: assert property (output_card_strobe |-> !mode.input_select && card_word.slot != 4'hf)
		else $error("bad output strobe");
	chk_arm_in: assert property (input_card_arm |-> mode.input_select && !output_card_strobe)
		else $error("bad input arm");
	chk_hs_ready: assert property (!mode.wait_timing_mode && !mode.input_select |-> lo_q <= HS_CYCLES + 2)
		else $error("handshake flag late");
	chk_wait_busy: assert property ((mode.wait_timing_mode && !data_ready) throughout s_busy |=> !data_ready)
		else $error("flag ready while busy");
	chk_int_ready: assert property (mode.input_select && mode.input_interrupt_enable && $rose(card_input_ready) |-> ##[1:6] data_ready)
		else $error("no interrupt flag");
endmodule

/* File: testbench/hwd_host_model.sv */
module hwd_host_model (
	input wire logic    core_clk,
	input wire logic    output_card_strobe,
	input wire logic    input_card_arm,
	output logic [15:0] host_word,
	output logic        host_gate_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic got_s;
	logic got_a;
	initial host_word = 16'h0000;
	initial host_gate_strobe = 1'b0;
	// The host card latches its word lines, so the word is held after the gate.
	task automatic send(input logic [15:0] w, input logic g);
		host_word = w;
		got_s = 1'b0;
		got_a = 1'b0;
		repeat (80) @(posedge core_clk);
		#1 host_gate_strobe = g;
		@(posedge core_clk) #1;
		host_gate_strobe = 1'b0;
		repeat (20) begin
			@(posedge core_clk) #1;
			got_s |= output_card_strobe;
			got_a |= input_card_arm;
		end
	endtask
endmodule

/* File: testbench/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic               core_clk = 1'b0;
	logic               reset = 1'b1;
	logic               flag_override_busy = 1'b0;
	logic               card_input_request = 1'b1;
	logic [11:0]        card_return_data = 12'h000;
	logic               card_input_ready = 1'b0;
	logic [15:0]        host_word;
	logic               host_gate_strobe;
	logic [15:0]        return_data;
	logic               data_ready;
	logic [15:0]        unit_select;
	hwd_pkg::hwd_mode_t mode;
	hwd_pkg::hwd_word_t card_word;
	logic               output_card_strobe;
	logic               input_card_arm;
	int                 n_errors = 0;
	int                 num_checks = 0;
	int                 em;
	logic [15:0]        w;
	always #50 core_clk = ~core_clk;
	hwd_decoder #(.HS_CYCLES(5)) hwd_decoder_inst (.core_clk(core_clk), .reset(reset),
		.clk_en(1'b1), .host_word(host_word), .host_gate_strobe(host_gate_strobe),
		.flag_override_busy(flag_override_busy), .card_input_request(card_input_request),
		.card_return_data(card_return_data), .card_input_ready(card_input_ready),
		.return_data(return_data), .data_ready(data_ready), .unit_select(unit_select),
		.mode(mode), .card_word(card_word), .output_card_strobe(output_card_strobe),
		.input_card_arm(input_card_arm));
	hwd_host_model hwd_host_model_inst (.core_clk(core_clk), .host_word(host_word),
		.output_card_strobe(output_card_strobe), .input_card_arm(input_card_arm),
		.host_gate_strobe(host_gate_strobe));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic wait_ready();
		for (int i = 0; i < 600; i++) begin
			if (data_ready === 1'b1) return;
			@(posedge core_clk) #1;
		end
		n_errors++;
		results();
	endtask
	task automatic ctl(input int m);
		em = m;
		hwd_host_model_inst.send({4'hf, 3'($urandom), m[8:0]}, 1'b1);
		wait_ready();
		check(16'(mode), 16'(em[8:0]));
		check(unit_select, 16'h0001 << em[3:0]);
	endtask
	task automatic dat(input logic g);
		w = 16'($urandom_range(32'hefff));
		hwd_host_model_inst.send(w, g);
		if (!flag_override_busy) wait_ready();
		check(16'(hwd_host_model_inst.got_s), 16'(g & !em[7]));
		check(16'(hwd_host_model_inst.got_a), 16'(g & em[7]));
		check(unit_select, 16'h0001 << em[3:0]);
		if (em[7]) check(return_data, {card_input_request, 3'h0, card_return_data});
		else check(return_data & 16'h8fff, w & 16'h8fff);
		if (g & !em[7]) check(16'(card_word), w);
	endtask
	initial begin
		void'($urandom(32'h039f));
		repeat (10) @(posedge core_clk);
		#1 reset = 1'b0;
		check(16'(mode), 16'h0000);
		check(unit_select, 16'h0001);
		$display("reset test done");
		for (int u = 0; u < 16; u++) ctl(($urandom & 32'h1f0) | u);
		ctl(32'h020);
		repeat (4) dat(1'b1);
		dat(1'b0);
		$display("output test done");
		ctl(32'h031);
		flag_override_busy = 1'b1;
		dat(1'b1);
		check(16'(data_ready), 16'h0000);
		flag_override_busy = 1'b0;
		wait_ready();
		$display("timing test done");
		card_return_data = 12'($urandom);
		ctl(32'h185);
		hwd_host_model_inst.send({4'h3, 12'($urandom)}, 1'b1);
		check(16'(hwd_host_model_inst.got_a), 16'h0001);
		check(16'(hwd_host_model_inst.got_s), 16'h0000);
		check(16'(card_word.slot), 16'h0003);
		check(unit_select, 16'h0020);
		check(return_data, {card_input_request, 3'h0, card_return_data});
		check(16'(data_ready), 16'h0000);
		card_input_ready = 1'b1;
		repeat (6) @(posedge core_clk) #1;
		check(16'(data_ready), 16'h0001);
		ctl(32'h085);
		card_return_data = 12'($urandom);
		card_input_request = 1'b0;
		dat(1'b0);
		$display("input test done");
		reset = 1'b1;
		repeat (2) @(posedge core_clk) #1;
		reset = 1'b0;
		check(16'(mode), 16'h0000);
		check(unit_select, 16'h0001);
		$display("second reset test done");
		results();
	end
endmodule
bind hwd_decoder hwd_monitor #(.HS_CYCLES(HS_CYCLES)) hwd_monitor_inst (.core_clk(core_clk),
	.reset(reset), .flag_override_busy(flag_override_busy), .card_input_ready(card_input_ready),
	.data_ready(data_ready), .unit_select(unit_select), .mode(mode), .card_word(card_word),
	.output_card_strobe(output_card_strobe), .input_card_arm(input_card_arm));
